// File: design/soft_option_mirror_ext_params.svh
// Offsets, field positions, reset values and timing counts for the
// soft option mirror and extended device control registers.
// Assumes a 32-bit word bus addressed in bytes.
`ifndef SOFT_OPTION_MIRROR_EXT_PARAMS_SVH
`define SOFT_OPTION_MIRROR_EXT_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SOFT_OPTION_MIRROR_OFS 5'h0c
`define EXT_DEVICE_CONTROL_OFS 5'h18
`define BUS_ADDR_WIDTH 5

// ----------------------------------------------------------------
// Soft option mirror layout
// ----------------------------------------------------------------
`define SOM_RESET 32'h0000_0001
`define SOM_NVM_SIZE_LSB 1
`define SOM_NVM_SIZE_MSB 5
`define SOM_SMT_FREQ_LSB 12
`define SOM_PHY_ATTACH_LSB 14
`define SOM_CTRL_SMB_VALID 16
`define SOM_CTRL_SMB_ADDR_LSB 17
`define SOM_PHY_SMB_VALID 24
`define SOM_PHY_SMB_ADDR_LSB 25

// ----------------------------------------------------------------
// Extended device control layout
// ----------------------------------------------------------------
`define EDC_GOOD_SECTOR_LSB 0
`define EDC_CYCLE_DONE 2
`define EDC_LSEC_OFF 12
`define EDC_SPEED_OVERRIDE 15
`define EDC_LSEC_OFF_RESET 1'b1
`define EDC_SPEED_OVERRIDE_RESET 1'b0
`define GOOD_SECTOR_RESET 2'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ 100_000_000
`define PHY_CYCLE_SHORT_MS 50
`define PHY_CYCLE_LONG_MS 100
`define PHY_CYCLE_SHORT_CYC (`PHY_CYCLE_SHORT_MS * (`CLK_HZ / 1000))
`define PHY_CYCLE_LONG_CYC (`PHY_CYCLE_LONG_MS * (`CLK_HZ / 1000))
`define PHY_CYCLE_CNT_WIDTH 24

`endif

// File: design/soft_option_mirror_ext_pkg.sv
// Types shared by the soft option and extended control register bank.
// Assumes the params header supplies the field widths.
`include "soft_option_mirror_ext_params.svh"

package soft_option_mirror_ext_pkg;

	typedef logic [1:0] speed_type;

	typedef struct packed {
		logic [`PHY_CYCLE_CNT_WIDTH-1:0] count;
		logic pin_prev;
		logic done;
	} cycle_timer_state_type;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic [31:0] mirror;
		logic armed;
		logic flr_prev;
		logic good_prev;
		logic [1:0] good_sector;
		logic lsec_off;
		logic speed_override;
		logic lsec_clock_enable;
		speed_type speed;
		logic speed_immediate;
	} regs_state_type;

endpackage

// File: design/phy_power_cycle_timer.sv
// Delay from PHY power control assertion to power cycle done.
// Assumes the power control pin is synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "soft_option_mirror_ext_params.svh"

module phy_power_cycle_timer #(
	parameter int unsigned SHORT_CYCLES = `PHY_CYCLE_SHORT_CYC,
	parameter int unsigned LONG_CYCLES = `PHY_CYCLE_LONG_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic power_control_i,
	input wire logic long_delay_i,
	input wire logic power_good_i,
	output logic done_o
);
	import soft_option_mirror_ext_pkg::*;

	localparam logic [`PHY_CYCLE_CNT_WIDTH-1:0] SHORT_LAST =
		`PHY_CYCLE_CNT_WIDTH'(SHORT_CYCLES - 1);
	localparam logic [`PHY_CYCLE_CNT_WIDTH-1:0] LONG_LAST =
		`PHY_CYCLE_CNT_WIDTH'(LONG_CYCLES - 1);

	cycle_timer_state_type state;
	cycle_timer_state_type next_state;
	logic [`PHY_CYCLE_CNT_WIDTH-1:0] last;

	// ------------------------------------------------------------
	// Delay count
	// ------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		last = long_delay_i ? LONG_LAST : SHORT_LAST;
		next_state.pin_prev = power_control_i;
		if (!power_good_i || !power_control_i)
		begin
			next_state.done = 1'b0;
			next_state.count = '0;
		end
		else if (!state.pin_prev)
		begin
			next_state.count = '0;
		end
		else if (!state.done)
		begin
			if (state.count == last)
				next_state.done = 1'b1;
			else
				next_state.count = state.count + 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state <= '0;
		else
			state <= next_state;
	end

	assign done_o = state.done;

endmodule
`default_nettype wire

// File: design/soft_option_mirror_and_ext_control_regs.sv
// Soft option mirror and extended device control registers.
// Assumes a classic Wishbone master and soft option inputs that are
// stable while the function level reset is asserted.
//
// Contract
// - Soft options are captured when function reset releases after power good or a global reset.
// - Mirror bits 5:1 give memory size in 4KB units, code zero meaning 4KB, up to 128KB.
// - Mirror bits 13:12 hold link frequency and 15:14 the PHY attach option, read-only, reset zero.
// - Mirror bit 16 is the controller bus address valid flag and bits 23:17 its address.
// - Mirror bit 24 is the PHY bus address valid flag and bits 31:25 its address.
// - Control bits 1:0 show the good memory sector: none, reserved, sector 0, sector 1.
// - Control bit 2 sets 50 or 100 ms after the PHY power control pin asserts.
// - Control bit 2 clears on power good and whenever the power control pin deasserts.
// - Control bit 12 set stops all clocks to the link security logic, clear lets them run.
// - Control bit 12 resets to one and loads from memory word 13h.
// - With the gating disable fuse set hardware sees bit 12 as zero, reads show the stored value.
// - Control bit 15 set bypasses speed detection and takes the main control speed at once.
// - With bit 15 set a speed change does not wait for clock switching to finish.
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "soft_option_mirror_ext_params.svh"

module soft_option_mirror_and_ext_control_regs #(
	parameter int unsigned SHORT_CYCLES = `PHY_CYCLE_SHORT_CYC,
	parameter int unsigned LONG_CYCLES = `PHY_CYCLE_LONG_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [`BUS_ADDR_WIDTH-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Resets and power
	input wire logic lan_power_good_i,
	input wire logic host_bus_reset_i,
	input wire logic function_level_reset_i,
	// Soft options from the memory descriptor
	input wire logic [4:0] nvm_size_code_i,
	input wire logic [1:0] smt_frequency_i,
	input wire logic [1:0] phy_attach_select_i,
	input wire logic controller_smb_addr_valid_i,
	input wire logic [6:0] controller_smb_addr_i,
	input wire logic phy_smb_addr_valid_i,
	input wire logic [6:0] phy_smb_addr_i,
	// Memory load
	input wire logic [1:0] nvm_good_sector_i,
	input wire logic nvm_load_i,
	input wire logic nvm_word13_lsec_off_i,
	// PHY power cycle
	input wire logic phy_power_control_pin_i,
	input wire logic phy_cycle_long_i,
	// Link security clock
	input wire logic clock_gating_disable_fuse_i,
	output logic link_security_clock_enable_o,
	// Speed selection and PHY power cycle done
	input wire soft_option_mirror_ext_pkg::speed_type mac_speed_field_i,
	input wire soft_option_mirror_ext_pkg::speed_type detected_speed_i,
	input wire logic clock_switch_done_i,
	output soft_option_mirror_ext_pkg::speed_type speed_o,
	output logic speed_immediate_o,
	output logic phy_power_cycle_complete_o
);
	import soft_option_mirror_ext_pkg::*;

	regs_state_type state;
	regs_state_type next_state;
	logic cycle_done;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic hit(
		input logic [`BUS_ADDR_WIDTH-1:0] adr,
		input logic [`BUS_ADDR_WIDTH-1:0] ofs
	);
		hit = (adr[`BUS_ADDR_WIDTH-1:2] == ofs[`BUS_ADDR_WIDTH-1:2]);
	endfunction

	function automatic logic [31:0] pack_mirror(
		input logic [4:0] size_code,
		input logic [1:0] freq,
		input logic [1:0] attach,
		input logic ctl_valid,
		input logic [6:0] ctl_addr,
		input logic phy_valid,
		input logic [6:0] phy_addr
	);
		logic [31:0] w;
		w = `SOM_RESET;
		w[`SOM_NVM_SIZE_MSB:`SOM_NVM_SIZE_LSB] = size_code;
		w[`SOM_SMT_FREQ_LSB+:2] = freq;
		w[`SOM_PHY_ATTACH_LSB+:2] = attach;
		w[`SOM_CTRL_SMB_VALID] = ctl_valid;
		w[`SOM_CTRL_SMB_ADDR_LSB+:7] = ctl_addr;
		w[`SOM_PHY_SMB_VALID] = phy_valid;
		w[`SOM_PHY_SMB_ADDR_LSB+:7] = phy_addr;
		pack_mirror = w;
	endfunction

	function automatic logic [31:0] pack_control(
		input logic [1:0] sector,
		input logic done,
		input logic lsec_off,
		input logic override
	);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`EDC_GOOD_SECTOR_LSB+:2] = sector;
		w[`EDC_CYCLE_DONE] = done;
		w[`EDC_LSEC_OFF] = lsec_off;
		w[`EDC_SPEED_OVERRIDE] = override;
		pack_control = w;
	endfunction

	// ------------------------------------------------------------
	// Power cycle delay
	// ------------------------------------------------------------
	phy_power_cycle_timer #(
		.SHORT_CYCLES(SHORT_CYCLES),
		.LONG_CYCLES(LONG_CYCLES)
	) cycle_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.power_control_i(phy_power_control_pin_i),
		.long_delay_i(phy_cycle_long_i),
		.power_good_i(lan_power_good_i),
		.done_o(cycle_done)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_state.good_prev = lan_power_good_i;
		next_state.flr_prev = function_level_reset_i;

		// Capture is armed by power good rising or a global reset
		if ((lan_power_good_i && !state.good_prev) ||
			(host_bus_reset_i && function_level_reset_i))
		begin
			next_state.armed = 1'b1;
		end
		else if (state.flr_prev && !function_level_reset_i &&
			state.armed)
		begin
			next_state.armed = 1'b0;
			next_state.mirror = pack_mirror(nvm_size_code_i,
				smt_frequency_i, phy_attach_select_i,
				controller_smb_addr_valid_i, controller_smb_addr_i,
				phy_smb_addr_valid_i, phy_smb_addr_i);
		end

		// Memory load sets the sector view and the gate bit
		if (nvm_load_i)
		begin
			next_state.good_sector = nvm_good_sector_i;
			next_state.lsec_off = nvm_word13_lsec_off_i;
		end

		// Bus access
		next_state.ack = cyc_i && stb_i && !state.ack;
		next_state.dat = 32'h0000_0000;
		if (cyc_i && stb_i && !state.ack)
		begin
			if (hit(adr_i, `SOFT_OPTION_MIRROR_OFS))
			begin
				next_state.dat = state.mirror;
			end
			else if (hit(adr_i, `EXT_DEVICE_CONTROL_OFS))
			begin
				next_state.dat = pack_control(state.good_sector,
					cycle_done, state.lsec_off,
					state.speed_override);
				if (we_i && sel_i[1])
				begin
					next_state.lsec_off = dat_i[`EDC_LSEC_OFF];
					next_state.speed_override =
						dat_i[`EDC_SPEED_OVERRIDE];
				end
			end
		end

		// Fuse masks the gate bit toward the logic, not the readback
		next_state.lsec_clock_enable =
			!(state.lsec_off && !clock_gating_disable_fuse_i);

		// Speed selection
		next_state.speed_immediate = state.speed_override;
		if (state.speed_override)
			next_state.speed = mac_speed_field_i;
		else if (clock_switch_done_i)
			next_state.speed = detected_speed_i;
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state <= '0;
			state.mirror <= `SOM_RESET;
			state.armed <= 1'b1;
			state.flr_prev <= 1'b0;
			state.good_sector <= `GOOD_SECTOR_RESET;
			state.lsec_off <= `EDC_LSEC_OFF_RESET;
			state.speed_override <= `EDC_SPEED_OVERRIDE_RESET;
			state.lsec_clock_enable <= 1'b0;
		end
		else
		begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign ack_o = state.ack;
	assign dat_o = state.dat;
	assign link_security_clock_enable_o = state.lsec_clock_enable;
	assign speed_o = state.speed;
	assign speed_immediate_o = state.speed_immediate;
	assign phy_power_cycle_complete_o = cycle_done;

endmodule
`default_nettype wire

// File: tb/soft_option_mirror_ext_asserts.sv
// Checker for the soft_option_mirror and extended control register bank.
// Bound to the top module; sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module soft_option_mirror_ext_checker #(
	parameter int unsigned SHORT_CYCLES = 20
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic lan_power_good_i,
	input wire logic phy_power_control_pin_i,
	input wire logic phy_power_cycle_complete_o,
	input wire logic clock_gating_disable_fuse_i,
	input wire logic link_security_clock_enable_o,
	input wire soft_option_mirror_ext_pkg::speed_type mac_speed_field_i,
	input wire soft_option_mirror_ext_pkg::speed_type speed_o,
	input wire logic speed_immediate_o
);
	import soft_option_mirror_ext_pkg::*;
	// Edges seen with the power control pin held high
	logic [7:0] run;
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !phy_power_control_pin_i)
			run <= 8'h00;
		else if (run != 8'hff)
			run <= run + 8'h01;
	end
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("bus request not answered next cycle");
	chk_ack_drop: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	chk_idle_zero: assert property (!ack_o |-> dat_o == 32'h0000_0000)
		else $error("read data not zero outside ack");
	chk_done_pin: assert property (
		!phy_power_control_pin_i |=> !phy_power_cycle_complete_o)
		else $error("cycle done kept with pin low");
	chk_done_power: assert property (
		!lan_power_good_i |=> !phy_power_cycle_complete_o)
		else $error("cycle done kept without power good");
	chk_done_delay: assert property (
		phy_power_cycle_complete_o |-> run >= SHORT_CYCLES)
		else $error("cycle done set too early");
	chk_fuse_enable: assert property (
		clock_gating_disable_fuse_i [*2] |-> link_security_clock_enable_o)
		else $error("fuse did not keep clock enabled");
	chk_speed_bypass: assert property (
		speed_immediate_o && $past(speed_immediate_o) |->
		speed_o == $past(mac_speed_field_i))
		else $error("bypass speed not taken");
	cover property ($rose(phy_power_cycle_complete_o));
	cover property (ack_o && dat_o != 32'h0000_0000);
	cover property (speed_immediate_o);
endmodule

bind soft_option_mirror_and_ext_control_regs soft_option_mirror_ext_checker
	#(.SHORT_CYCLES(SHORT_CYCLES)) u_chk (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.cyc_i(cyc_i),
	.stb_i(stb_i),
	.dat_o(dat_o),
	.ack_o(ack_o),
	.lan_power_good_i(lan_power_good_i),
	.phy_power_control_pin_i(phy_power_control_pin_i),
	.phy_power_cycle_complete_o(phy_power_cycle_complete_o),
	.clock_gating_disable_fuse_i(clock_gating_disable_fuse_i),
	.link_security_clock_enable_o(link_security_clock_enable_o),
	.mac_speed_field_i(mac_speed_field_i),
	.speed_o(speed_o),
	.speed_immediate_o(speed_immediate_o)
);

`default_nettype wire

// File: tb/test_soft_option_mirror_and_ext_control_regs.sv
// Self-checking bench for the soft_option_mirror and extended control bank.
// Drives every port itself; bus reads are checked from a queue.
`timescale 1ns/1ps
`default_nettype none
`include "soft_option_mirror_ext_params.svh"

module test_soft_option_mirror_and_ext_control_regs;
	import soft_option_mirror_ext_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
	logic we_i = 1'b0, ack_o, speed_immediate_o;
	logic [4:0] adr_i = 5'h00, nvm_size_code_i = 5'h00;
	logic [3:0] sel_i = 4'h2;
	logic [31:0] dat_i = 32'h0000_0000, dat_o, r, q[$];
	logic [31:0] rnd = 32'hfe4d_c8c1;
	logic link_security_clock_enable_o, phy_power_cycle_complete_o;
	logic lan_power_good_i = 1'b1, host_bus_reset_i = 1'b0;
	logic function_level_reset_i = 1'b0, nvm_load_i = 1'b0;
	logic controller_smb_addr_valid_i = 1'b0, phy_smb_addr_valid_i = 1'b0;
	logic nvm_word13_lsec_off_i = 1'b0, phy_power_control_pin_i = 1'b0;
	logic phy_cycle_long_i = 1'b0, clock_gating_disable_fuse_i = 1'b0;
	logic clock_switch_done_i = 1'b0;
	logic [1:0] smt_frequency_i = 2'h0, phy_attach_select_i = 2'h0;
	logic [1:0] nvm_good_sector_i = 2'h0;
	logic [6:0] controller_smb_addr_i = 7'h00, phy_smb_addr_i = 7'h00;
	speed_type mac_speed_field_i = 2'h0, detected_speed_i = 2'h0;
	speed_type speed_o, sp;
	int err_total = 0, n_tests = 0, i;

	soft_option_mirror_and_ext_control_regs #(.SHORT_CYCLES(20), .LONG_CYCLES(40))
		dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cyc_i(cyc_i),
		.stb_i(stb_i),
		.we_i(we_i),
		.adr_i(adr_i),
		.sel_i(sel_i),
		.dat_i(dat_i),
		.dat_o(dat_o),
		.ack_o(ack_o),
		.lan_power_good_i(lan_power_good_i),
		.host_bus_reset_i(host_bus_reset_i),
		.function_level_reset_i(function_level_reset_i),
		.nvm_size_code_i(nvm_size_code_i),
		.smt_frequency_i(smt_frequency_i),
		.phy_attach_select_i(phy_attach_select_i),
		.controller_smb_addr_valid_i(controller_smb_addr_valid_i),
		.controller_smb_addr_i(controller_smb_addr_i),
		.phy_smb_addr_valid_i(phy_smb_addr_valid_i),
		.phy_smb_addr_i(phy_smb_addr_i),
		.nvm_good_sector_i(nvm_good_sector_i),
		.nvm_load_i(nvm_load_i),
		.nvm_word13_lsec_off_i(nvm_word13_lsec_off_i),
		.phy_power_control_pin_i(phy_power_control_pin_i),
		.phy_cycle_long_i(phy_cycle_long_i),
		.clock_gating_disable_fuse_i(clock_gating_disable_fuse_i),
		.link_security_clock_enable_o(link_security_clock_enable_o),
		.mac_speed_field_i(mac_speed_field_i),
		.detected_speed_i(detected_speed_i),
		.clock_switch_done_i(clock_switch_done_i),
		.speed_o(speed_o),
		.speed_immediate_o(speed_immediate_o),
		.phy_power_cycle_complete_o(phy_power_cycle_complete_o)
	);

	always #5 clk_i = ~clk_i;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task complete_run();
		if (err_total == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// For reads d is the expected word, for writes the data
	task bus(input int w, input logic [4:0] a, input logic [31:0] d);
		int n;
		if (w == 0)
			q.push_back(d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= (w != 0);
		adr_i <= a;
		dat_i <= d;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'b1 && n < 50);
		if (ack_o !== 1'b1)
		begin
			err_total++;
			complete_run();
		end
		else
		begin
			cyc_i <= 1'b0;
			stb_i <= 1'b0;
			@(posedge clk_i);
		end
	endtask

	always @(posedge clk_i)
		if (ack_o === 1'b1 && !we_i)
			check(dat_o, q.pop_front());

	// ------------------------------------------------------------
	// Stimulus
	// ------------------------------------------------------------
	initial
	begin
		tick(8);
		rst_i <= 1'b0;
		tick(1);
		bus(0, `SOFT_OPTION_MIRROR_OFS, `SOM_RESET);
		bus(0, `EXT_DEVICE_CONTROL_OFS, 32'h0000_1000);
		bus(0, 5'h04, 32'h0000_0000);
		// Third pass has no arming event: mirror must keep its value
		for (i = 0; i < 3; i++)
		begin
			rnd = xs(rnd);
			{phy_smb_addr_i, phy_smb_addr_valid_i, controller_smb_addr_i,
				controller_smb_addr_valid_i, phy_attach_select_i,
				smt_frequency_i} <= rnd[31:12];
			nvm_size_code_i <= rnd[5:1];
			host_bus_reset_i <= (i == 1);
			function_level_reset_i <= 1'b1;
			tick(2);
			function_level_reset_i <= 1'b0;
			host_bus_reset_i <= 1'b0;
			tick(3);
			if (i < 2)
				r = {rnd[31:12], 6'h00, rnd[5:1], 1'b1};
			bus(1, `SOFT_OPTION_MIRROR_OFS, ~r);
			bus(0, `SOFT_OPTION_MIRROR_OFS, r);
		end
		for (i = 0; i < 4; i++)
		begin
			nvm_good_sector_i <= i[1:0];
			nvm_word13_lsec_off_i <= i[0];
			nvm_load_i <= 1'b1;
			tick(1);
			nvm_load_i <= 1'b0;
			tick(1);
			r = {19'h0_0000, i[0], 10'h000, i[1:0]};
			bus(0, `EXT_DEVICE_CONTROL_OFS, r);
		end
		// Nonzero so that a speed stuck at its reset value is caught
		sp = {rnd[0], 1'b1};
		mac_speed_field_i <= sp;
		detected_speed_i <= ~sp;
		bus(1, `EXT_DEVICE_CONTROL_OFS, 32'hffff_ffff);
		bus(0, `EXT_DEVICE_CONTROL_OFS, 32'h0000_9003);
		check(32'(link_security_clock_enable_o), 32'h0);
		check({30'h0, speed_o}, {30'h0, sp});
		check(32'(speed_immediate_o), 32'h1);
		// Write without byte lane 1 must be ignored
		sel_i <= 4'hd;
		bus(1, `EXT_DEVICE_CONTROL_OFS, 32'h0000_0000);
		sel_i <= 4'h2;
		mac_speed_field_i <= ~sp;
		tick(2);
		check({30'h0, speed_o}, {30'h0, ~sp});
		mac_speed_field_i <= sp;
		clock_gating_disable_fuse_i <= 1'b1;
		tick(3);
		check(32'(link_security_clock_enable_o), 32'h1);
		bus(0, `EXT_DEVICE_CONTROL_OFS, 32'h0000_9003);
		clock_gating_disable_fuse_i <= 1'b0;
		bus(1, `EXT_DEVICE_CONTROL_OFS, 32'h0000_0000);
		bus(0, `EXT_DEVICE_CONTROL_OFS, 32'h0000_0003);
		check(32'(link_security_clock_enable_o), 32'h1);
		check({30'h0, speed_o}, {30'h0, sp});
		check(32'(speed_immediate_o), 32'h0);
		clock_switch_done_i <= 1'b1;
		tick(3);
		sp = ~sp;
		check({30'h0, speed_o}, {30'h0, sp});
		for (i = 0; i < 2; i++)
		begin
			phy_cycle_long_i <= i[0];
			phy_power_control_pin_i <= 1'b1;
			tick(15 + 20 * i);
			check(32'(phy_power_cycle_complete_o), 32'h0);
			tick(10);
			check(32'(phy_power_cycle_complete_o), 32'h1);
			bus(0, `EXT_DEVICE_CONTROL_OFS, 32'h0000_0007);
			if (i == 0)
				phy_power_control_pin_i <= 1'b0;
			else
				lan_power_good_i <= 1'b0;
			tick(2);
			check(32'(phy_power_cycle_complete_o), 32'h0);
		end
		lan_power_good_i <= 1'b1;
		phy_power_control_pin_i <= 1'b0;
		tick(2);
		// Reset in mid-run brings both registers back to initial values
		rst_i <= 1'b1;
		tick(2);
		rst_i <= 1'b0;
		tick(1);
		check(32'(link_security_clock_enable_o), 32'h0);
		bus(0, `SOFT_OPTION_MIRROR_OFS, `SOM_RESET);
		bus(0, `EXT_DEVICE_CONTROL_OFS, 32'h0000_1000);
		complete_run();
	end
endmodule

`default_nettype wire
